// file: rtl/cgc_top.sv
// Notes on behaviour
// - cpu clock failure goes to nmi when enabled
// - cpu clock failure resets only when enabled
// - slow crystal monitor runs only when enabled
// - clock failure detector works only when enabled
// - source select: 0 rc, 1 external clock
// - oscillator writes need key; key reads zero
// - crystal start-up is value times eight ticks
// - rc frequency changes only when stable, alone
// - stable flags rise after start-up time, except the external one in bypass
// - bypass sets stable flag; clearing both clears
// - counter source: 0 rc, 1 external clock
// - restart bit clears ready, restarts measurement
// - count is edges within sixteen slow ticks
// - ready low while invalid, disabled or restarted
// - multiplier zero disables; factor is value plus one
// - prediv zero disables, one bypasses, up to 64
// - vco range field selects oscillator range
// - lock flag waits lock count slow ticks
// - pll b source: 0 main, else second rc
// - write protect blocks configuration writes
//
// Design decision made here: strobed register access.
`default_nettype none
module cgc_top
	import cgc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	// system inputs
	input wire logic writeProtectEnable,
	input wire logic monitorSlowClock,
	input wire logic rcClock,
	input wire logic extClock,
	input wire logic cpuClockFail,
	input wire logic mainClockFail,
	// failure handling
	output logic nmiRequest,
	output logic cpuFailResetReq,
	output logic slowXtalFreqMonitorEn,
	output logic clockFailureDetectorEn,
	output logic clockFailureDetected,
	// oscillator control
	output logic mainSourceSelect,
	output logic rcOscEnable,
	output logic [2:0] rcFreqSelect,
	output logic xtalOscEnable,
	output logic xtalBypass,
	output logic rcStableFlag,
	output logic extClockStableFlag,
	// plls
	output logic [1:0] pllEnable,
	output logic [1:0][11:0] pllFactor,
	output logic [1:0][7:0] pllPrediv,
	output logic [1:0][1:0] vcoRange,
	output logic pllBSecondRc,
	output logic pllALocked,
	output logic pllBLocked,
	output logic [31:0] masterClockConfig
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [31:0] mainOsc;
		logic [31:0] pllA;
		logic [31:0] pllB;
		logic [31:0] mclk;
		logic counterSrc;
		logic [15:0] freqCount;
		logic readyRaw;
		logic readyFlag;
		cgc_meas_e measState;
		logic [4:0] winCnt;
		logic [15:0] edgeCnt;
		logic slowPrev;
		logic rcPrev;
		logic extPrev;
		logic [31:0] rdData;
		logic nmiReq;
		logic cpuRstReq;
		logic cfdFault;
		logic rcStable;
		logic xtStable;
		logic [1:0] locked;
		logic [1:0] pllEn;
		logic [1:0][11:0] factor;
		logic [1:0][7:0] prediv;
		logic [1:0][1:0] vco;
		logic pllBRc;
	} cgc_top_s;

	localparam cgc_top_s RST_STATE = '{mainOsc: MOR_RESET, pllA: PLL_RESET, pllB: PLL_RESET,
		mclk: MCLK_RESET, freqCount: MCFR_RESET[15:0], readyRaw: 1'b1, readyFlag: 1'b1,
		measState: MEAS_IDLE, rcStable: 1'b1, default: '0};

	cgc_top_s q;
	cgc_top_s d;
	logic [1:0] rstSync;
	logic rstN;
	logic [3:0] tmrStart;
	logic [3:0] tmrRun;
	logic [3:0][TMR_W-1:0] tmrLoad;
	logic [3:0] tmrDone;
	logic slowTick;
	logic wrOk;
	logic morWr;
	logic mcfrWr;
	logic [1:0] pllWr;
	logic measOscOn;
	logic measEdge;
	logic keepRcFreq;
	logic [31:0] morNew;

	// pll runs only with legal multiplier and predivider
	function automatic logic pll_ok(input logic [31:0] cfg);
		logic [10:0] mul;
		logic [7:0] div;
		mul = cfg[PLL_MUL_LSB +: 11];
		div = cfg[7:0];
		pll_ok = (mul != 11'h000) && (mul <= PLL_MUL_MAX) && (div != 8'h00) && (div <= PLL_DIV_MAX);
	endfunction : pll_ok

	// ****************************************
	// reset release
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// ****************************************
	// slow clock timers
	// ****************************************
	assign slowTick = monitorSlowClock && !q.slowPrev;
	assign tmrStart[TMR_RC] = morWr && regWrData[MOR_RC_EN] && !q.mainOsc[MOR_RC_EN];
	assign tmrRun[TMR_RC] = q.mainOsc[MOR_RC_EN];
	assign tmrLoad[TMR_RC] = RC_STARTUP_TICKS;
	assign tmrStart[TMR_XT] = morWr && regWrData[MOR_XT_EN] && !q.mainOsc[MOR_XT_EN];
	assign tmrRun[TMR_XT] = q.mainOsc[MOR_XT_EN];
	// start-up value counts groups of eight slow ticks
	assign tmrLoad[TMR_XT] = {regWrData[MOR_XT_START_LSB +: 8], 3'h0};
	assign tmrStart[TMR_PLL_A +: 2] = pllWr;
	assign tmrRun[TMR_PLL_A] = pll_ok(q.pllA);
	assign tmrRun[TMR_PLL_A + 1] = pll_ok(q.pllB);
	assign tmrLoad[TMR_PLL_A] = {5'h00, regWrData[PLL_COUNT_LSB +: 6]};
	assign tmrLoad[TMR_PLL_A + 1] = {5'h00, regWrData[PLL_COUNT_LSB +: 6]};

	for (genvar i = 0; i < 4; i++) begin : g_tmr
		cgc_slow_timer #(
			.DONE_AT_RESET(i == TMR_RC)
		) u_tmr (
			.clk(clk),
			.rstN(rstN),
			.start(tmrStart[i]),
			.run(tmrRun[i]),
			.tick(slowTick),
			.loadTicks(tmrLoad[i]),
			.done(tmrDone[i])
		);
	end

	// ****************************************
	// register writes and measurement
	// ****************************************
	assign wrOk = regWrite && !writeProtectEnable;
	assign morWr = wrOk && regAddr == OFF_MAIN_OSC && regWrData[MOR_KEY_LSB +: 8] == MOR_KEY;
	assign mcfrWr = wrOk && regAddr == OFF_FREQ_MEAS;
	assign pllWr[0] = wrOk && regAddr == OFF_PLL_A;
	assign pllWr[1] = wrOk && regAddr == OFF_PLL_B;
	// frequency is kept when not stable or when the enable also moves
	assign keepRcFreq = !q.rcStable || (regWrData[MOR_RC_EN] != q.mainOsc[MOR_RC_EN]);
	assign morNew = (regWrData & MOR_RW_MASK & ~MOR_RCF_MASK)
		| (keepRcFreq ? (q.mainOsc & MOR_RCF_MASK) : (regWrData & MOR_RCF_MASK));
	assign measOscOn = q.counterSrc ? (q.mainOsc[MOR_XT_EN] || q.mainOsc[MOR_XT_BYPASS])
		: q.mainOsc[MOR_RC_EN];
	assign measEdge = q.counterSrc ? (extClock && !q.extPrev) : (rcClock && !q.rcPrev);

	always_comb begin
		d = q;
		d.slowPrev = monitorSlowClock;
		d.rcPrev = rcClock;
		d.extPrev = extClock;
		if (morWr) begin
			d.mainOsc = morNew;
		end
		if (pllWr[0]) begin
			d.pllA = regWrData & PLLA_RW_MASK;
		end
		if (pllWr[1]) begin
			d.pllB = regWrData & PLLB_RW_MASK;
		end
		if (wrOk && regAddr == OFF_MCLK) begin
			d.mclk = regWrData & MCLK_RW_MASK;
		end
		if (mcfrWr) begin
			d.counterSrc = regWrData[MCFR_SRC];
		end
		// measurement window
		case (q.measState)
			MEAS_IDLE: begin
			end
			MEAS_ARMED: begin
				if (slowTick) begin
					d.measState = MEAS_RUN;
					d.winCnt = '0;
					d.edgeCnt = '0;
				end
			end
			MEAS_RUN: begin
				if (measEdge && q.edgeCnt != 16'hFFFF) begin
					d.edgeCnt = q.edgeCnt + 16'h0001;
				end
				if (slowTick) begin
					d.winCnt = q.winCnt + 5'h01;
					if (d.winCnt == MEAS_WINDOW_TICKS) begin
						d.freqCount = d.edgeCnt;
						d.readyRaw = 1'b1;
						d.measState = MEAS_IDLE;
					end
				end
			end
			default: begin
				d.measState = MEAS_IDLE;
			end
		endcase
		// restart beats a window that ends in the same cycle
		if (mcfrWr && regWrData[MCFR_RESTART]) begin
			d.readyRaw = 1'b0;
			d.measState = MEAS_ARMED;
		end
		d.readyFlag = d.readyRaw && measOscOn;
		// status and outputs
		d.nmiReq = cpuClockFail && q.mainOsc[MOR_CPU_NMI];
		d.cpuRstReq = cpuClockFail && q.mainOsc[MOR_CPU_RST];
		d.cfdFault = mainClockFail && q.mainOsc[MOR_CFD_EN];
		d.rcStable = tmrDone[TMR_RC] && q.mainOsc[MOR_RC_EN];
		d.xtStable = q.mainOsc[MOR_XT_BYPASS] || (tmrDone[TMR_XT] && q.mainOsc[MOR_XT_EN]);
		d.locked = tmrDone[TMR_PLL_A +: 2];
		d.pllEn = {pll_ok(q.pllB), pll_ok(q.pllA)};
		d.factor[0] = d.pllEn[0] ? {1'b0, q.pllA[PLL_MUL_LSB +: 11]} + 12'h001 : 12'h000;
		d.factor[1] = d.pllEn[1] ? {1'b0, q.pllB[PLL_MUL_LSB +: 11]} + 12'h001 : 12'h000;
		d.prediv[0] = q.pllA[7:0];
		d.prediv[1] = q.pllB[7:0];
		d.vco[0] = q.pllA[PLL_VCO_LSB +: 2];
		d.vco[1] = q.pllB[PLL_VCO_LSB +: 2];
		d.pllBRc = q.pllB[PLLB_SRC_LSB +: 2] != 2'h0;
		// read data stand for one cycle only
		d.rdData = '0;
		if (regRead) begin
			case (regAddr)
				OFF_MAIN_OSC: d.rdData = q.mainOsc;
				OFF_FREQ_MEAS: begin
					d.rdData[15:0] = q.freqCount;
					d.rdData[MCFR_READY] = q.readyFlag;
					d.rdData[MCFR_SRC] = q.counterSrc;
				end
				OFF_PLL_A: d.rdData = q.pllA;
				OFF_PLL_B: d.rdData = q.pllB;
				OFF_MCLK: d.rdData = q.mclk;
				OFF_STATUS: begin
					d.rdData[ST_XT_STABLE] = q.xtStable;
					d.rdData[ST_LOCK_A] = q.locked[0];
					d.rdData[ST_LOCK_B] = q.locked[1];
					d.rdData[ST_RC_STABLE] = q.rcStable;
					d.rdData[ST_CFD_FAULT] = q.cfdFault;
				end
				default: d.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign regRdData = q.rdData;
	assign nmiRequest = q.nmiReq;
	assign cpuFailResetReq = q.cpuRstReq;
	assign slowXtalFreqMonitorEn = q.mainOsc[MOR_SLOW_MON];
	assign clockFailureDetectorEn = q.mainOsc[MOR_CFD_EN];
	assign clockFailureDetected = q.cfdFault;
	assign mainSourceSelect = q.mainOsc[MOR_SRC_SEL];
	assign rcOscEnable = q.mainOsc[MOR_RC_EN];
	assign rcFreqSelect = q.mainOsc[6:4];
	assign xtalOscEnable = q.mainOsc[MOR_XT_EN];
	assign xtalBypass = q.mainOsc[MOR_XT_BYPASS];
	assign rcStableFlag = q.rcStable;
	assign extClockStableFlag = q.xtStable;
	assign pllEnable = q.pllEn;
	assign pllFactor = q.factor;
	assign pllPrediv = q.prediv;
	assign vcoRange = q.vco;
	assign pllBSecondRc = q.pllBRc;
	assign pllALocked = q.locked[0];
	assign pllBLocked = q.locked[1];
	assign masterClockConfig = q.mclk;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstN);

	a_nmi_forward: assert property (cpuClockFail && q.mainOsc[MOR_CPU_NMI] |=> nmiRequest)
		else $error("cpu failure not forwarded to nmi");
	a_reset_gate: assert property (!q.mainOsc[MOR_CPU_RST] |=> !cpuFailResetReq)
		else $error("cpu failure reset while disabled");
	a_cfd_gate: assert property (!clockFailureDetectorEn |=> !clockFailureDetected)
		else $error("detector active while disabled");
	a_bad_key: assert property (regWrite && regAddr == OFF_MAIN_OSC
		&& regWrData[MOR_KEY_LSB +: 8] != MOR_KEY |=> $stable(q.mainOsc))
		else $error("write with wrong key took effect");
	a_key_zero: assert property (regRead && regAddr == OFF_MAIN_OSC
		|=> regRdData[MOR_KEY_LSB +: 8] == 8'h00)
		else $error("key field read nonzero");
	a_xt_tick: assert property ($rose(tmrDone[TMR_XT]) |-> $past(slowTick))
		else $error("crystal start-up ended off a slow tick");
	a_rcf_hold: assert property (morWr && !q.rcStable |=> $stable(rcFreqSelect))
		else $error("rc frequency changed while unstable");
	a_rc_start: assert property (tmrStart[TMR_RC] |=> ##1 !rcStableFlag)
		else $error("rc stable without start-up time");
	a_bypass_flag: assert property (xtalBypass |=> extClockStableFlag)
		else $error("bypass did not set stable flag");
	a_meas_restart: assert property (mcfrWr && regWrData[MCFR_RESTART]
		|=> ##1 !q.readyFlag)
		else $error("restart did not clear ready");
	a_ready_osc: assert property (!measOscOn |=> !q.readyFlag)
		else $error("ready with measured oscillator off");
	a_lock_clear: assert property (pllWr[0] |=> ##1 !pllALocked)
		else $error("lock kept across pll write");
	a_lock_off: assert property (!tmrRun[TMR_PLL_A] && !pllWr[0] |=> ##1 !pllALocked)
		else $error("locked while pll disabled");
	a_prediv_off: assert property (q.pllA[7:0] == 8'h00 |=> !pllEnable[0])
		else $error("pll enabled with zero predivider");
	a_wp_block: assert property (regWrite && writeProtectEnable
		|=> $stable(q.mainOsc) && $stable(q.pllA) && $stable(q.mclk))
		else $error("write accepted under write protect");

	c_lock_a: cover property ($rose(pllALocked));
	c_meas_done: cover property ($rose(q.readyRaw));
	c_bypass: cover property ($rose(extClockStableFlag) && xtalBypass);
endmodule : cgc_top
`default_nettype wire

// file: include/cgc_pkg.sv
`default_nettype none
package cgc_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFF_MAIN_OSC = 8'h20;
	localparam logic [7:0] OFF_FREQ_MEAS = 8'h24;
	localparam logic [7:0] OFF_PLL_A = 8'h28;
	localparam logic [7:0] OFF_PLL_B = 8'h2C;
	localparam logic [7:0] OFF_MCLK = 8'h30;
	localparam logic [7:0] OFF_STATUS = 8'h68;
	// ****************************************
	// main oscillator control fields
	// ****************************************
	localparam int MOR_XT_EN = 0;
	localparam int MOR_XT_BYPASS = 1;
	localparam int MOR_RC_EN = 3;
	localparam int MOR_XT_START_LSB = 8;
	localparam int MOR_KEY_LSB = 16;
	localparam int MOR_SRC_SEL = 24;
	localparam int MOR_CFD_EN = 25;
	localparam int MOR_SLOW_MON = 26;
	localparam int MOR_CPU_RST = 27;
	localparam int MOR_CPU_NMI = 28;
	localparam logic [7:0] MOR_KEY = 8'h37;
	localparam logic [31:0] MOR_RESET = 32'h0000_0008;
	localparam logic [31:0] MOR_RW_MASK = 32'h1F00_FF7B;
	localparam logic [31:0] MOR_RCF_MASK = 32'h0000_0070;
	// ****************************************
	// frequency measure fields
	// ****************************************
	localparam int MCFR_READY = 16;
	localparam int MCFR_RESTART = 20;
	localparam int MCFR_SRC = 24;
	localparam logic [31:0] MCFR_RESET = 32'h0001_147F;
	// ****************************************
	// pll fields
	// ****************************************
	localparam int PLL_COUNT_LSB = 8;
	localparam int PLL_VCO_LSB = 14;
	localparam int PLL_MUL_LSB = 16;
	localparam int PLLB_SRC_LSB = 29;
	localparam logic [31:0] PLL_RESET = 32'h0000_3F00;
	localparam logic [31:0] PLLA_RW_MASK = 32'h27FF_FFFF;
	localparam logic [31:0] PLLB_RW_MASK = 32'h67FF_FFFF;
	localparam logic [10:0] PLL_MUL_MAX = 11'h019;
	localparam logic [7:0] PLL_DIV_MAX = 8'h40;
	localparam logic [31:0] MCLK_RESET = 32'h0000_0001;
	localparam logic [31:0] MCLK_RW_MASK = 32'h0000_0173;
	// ****************************************
	// status bits
	// ****************************************
	localparam int ST_XT_STABLE = 0;
	localparam int ST_LOCK_A = 1;
	localparam int ST_LOCK_B = 2;
	localparam int ST_RC_STABLE = 17;
	localparam int ST_CFD_FAULT = 19;
	// ****************************************
	// slow clock timing
	// ****************************************
	localparam int TMR_W = 11;
	localparam int XT_STARTUP_SHIFT = 3;
	localparam logic [TMR_W-1:0] RC_STARTUP_TICKS = 11'h008;
	localparam logic [4:0] MEAS_WINDOW_TICKS = 5'h10;
	localparam int TMR_RC = 0;
	localparam int TMR_XT = 1;
	localparam int TMR_PLL_A = 2;
	typedef enum logic [1:0] {MEAS_IDLE, MEAS_ARMED, MEAS_RUN} cgc_meas_e;
endpackage : cgc_pkg
`default_nettype wire

// file: rtl/cgc_slow_timer.sv
`default_nettype none
module cgc_slow_timer
	import cgc_pkg::*;
#(
	parameter bit DONE_AT_RESET = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// control
	input wire logic start,
	input wire logic run,
	input wire logic tick,
	input wire logic [TMR_W-1:0] loadTicks,
	// status
	output logic done
);
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic busy;
		logic done;
	} cgc_tmr_s;
	localparam logic [TMR_W-1:0] TMR_ONE = 11'h001;
	cgc_tmr_s q;
	cgc_tmr_s d;

	always_comb begin
		d = q;
		if (start) begin
			d.cnt = loadTicks;
			d.busy = 1'b1;
			d.done = 1'b0;
		end else if (!run) begin
			d.busy = 1'b0;
			d.done = 1'b0;
		end else if (q.busy && tick) begin
			// a zero load still waits one slow tick
			if (q.cnt <= TMR_ONE) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - TMR_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			q <= '{cnt: '0, busy: 1'b0, done: DONE_AT_RESET};
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
endmodule : cgc_slow_timer
`default_nettype wire

// file: bench/cgc_osc_model.sv
`default_nettype none
module cgc_osc_model (
	// clock
	input wire logic clk,
	// oscillator enables
	input wire logic rcOscEnable,
	input wire logic xtalOscEnable,
	input wire logic xtalBypass,
	// clocks, sampled as data by the block
	output logic monitorSlowClock,
	output logic rcClock,
	output logic extClock
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] phase = 3'h0;
	// slow clock scaled to eight fast cycles so every count stays short
	always @(posedge clk) phase <= phase + 3'h1;
	assign monitorSlowClock = phase[2];
	// a stopped oscillator holds its output low, like a dead one
	assign rcClock = rcOscEnable & phase[1];
	// crystal and bypass feed the same pin; never both on at once
	assign extClock = (xtalOscEnable | xtalBypass) & phase[2];
endmodule : cgc_osc_model
`default_nettype wire

// file: bench/cgc_top_tb.sv
`default_nettype none
module cgc_top_tb import cgc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, regWrite, regRead, writeProtectEnable, cpuClockFail, mainClockFail;
	logic monitorSlowClock, rcClock, extClock, nmiRequest, cpuFailResetReq;
	logic slowXtalFreqMonitorEn, clockFailureDetectorEn, clockFailureDetected;
	logic mainSourceSelect, rcOscEnable, xtalOscEnable, xtalBypass;
	logic rcStableFlag, extClockStableFlag, pllBSecondRc, pllALocked, pllBLocked;
	logic [7:0] regAddr;
	logic [31:0] regWrData, regRdData, masterClockConfig, rdv, wv;
	logic [2:0] rcFreqSelect;
	logic [1:0] pllEnable;
	logic [1:0][11:0] pllFactor;
	logic [1:0][7:0] pllPrediv;
	logic [1:0][1:0] vcoRange;
	int n_mismatch, n_compared, i;
	logic [7:0] rstAddr [7] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h68, 8'h10};
	logic [31:0] rstVal [7] = '{32'h8, 32'h0001_147F, 32'h3F00, 32'h3F00, 32'h1,
		32'h0002_0000, 32'h0};
	logic [10:0] mulT [5] = '{11'h000, 11'h001, 11'h019, 11'h01A, 11'h001};
	logic [7:0] divT [5] = '{8'h01, 8'h00, 8'h40, 8'h01, 8'h41};
	logic enT [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

	cgc_top cgc_top_inst (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.writeProtectEnable(writeProtectEnable), .monitorSlowClock(monitorSlowClock),
		.rcClock(rcClock), .extClock(extClock), .cpuClockFail(cpuClockFail),
		.mainClockFail(mainClockFail), .nmiRequest(nmiRequest), .cpuFailResetReq(cpuFailResetReq),
		.slowXtalFreqMonitorEn(slowXtalFreqMonitorEn),
		.clockFailureDetectorEn(clockFailureDetectorEn),
		.clockFailureDetected(clockFailureDetected), .mainSourceSelect(mainSourceSelect),
		.rcOscEnable(rcOscEnable), .rcFreqSelect(rcFreqSelect), .xtalOscEnable(xtalOscEnable),
		.xtalBypass(xtalBypass), .rcStableFlag(rcStableFlag),
		.extClockStableFlag(extClockStableFlag), .pllEnable(pllEnable), .pllFactor(pllFactor),
		.pllPrediv(pllPrediv), .vcoRange(vcoRange), .pllBSecondRc(pllBSecondRc),
		.pllALocked(pllALocked), .pllBLocked(pllBLocked), .masterClockConfig(masterClockConfig));
	cgc_osc_model cgc_osc_model_inst (.clk(clk), .rcOscEnable(rcOscEnable),
		.xtalOscEnable(xtalOscEnable), .xtalBypass(xtalBypass),
		.monitorSlowClock(monitorSlowClock), .rcClock(rcClock), .extClock(extClock));

	// ****************************************
	// bus tasks and comparisons
	// ****************************************
	task automatic stop_test;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk32(input string name, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, e, g);
		end
	endtask : chk32
	task automatic chkBit(input string name, input logic e, input logic g);
		chk32(name, {31'h0, e}, {31'h0, g});
	endtask : chkBit
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input int bound);
		logic [31:0] d;
		int k;
		d = 32'h0;
		n_compared++;
		for (k = 0; k < bound; k++) begin
			rd(a, d);
			if ((d & m) === e) return;
		end
		n_mismatch++;
		$display("BAD poll of %h expected %h seen %h", a, e, d & m);
		stop_test();
	endtask : poll

	// ****************************************
	// clock and sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		writeProtectEnable = 1'b0;
		cpuClockFail = 1'b1;
		mainClockFail = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		cyc(4);
		for (i = 0; i < 7; i++) begin
			rd(rstAddr[i], rdv);
			chk32("reset value", rstVal[i], rdv);
		end
		chk32("rc freq at start", 32'h0, {29'h0, rcFreqSelect});
		chkBit("nmi while disabled", 1'b0, nmiRequest);
		chkBit("reset while disabled", 1'b0, cpuFailResetReq);
		chkBit("detector while disabled", 1'b0, clockFailureDetected);
		wr(OFF_MAIN_OSC, 32'h1F36_0008);
		rd(OFF_MAIN_OSC, rdv);
		chk32("bad key write", 32'h8, rdv);
		wr(OFF_MAIN_OSC, 32'h1F37_0008);
		rd(OFF_MAIN_OSC, rdv);
		chk32("good key write", 32'h1F00_0008, rdv);
		chkBit("nmi enabled", 1'b1, nmiRequest);
		chkBit("reset enabled", 1'b1, cpuFailResetReq);
		chkBit("detector fault", 1'b1, clockFailureDetected);
		chkBit("detector enable", 1'b1, clockFailureDetectorEn);
		chkBit("slow monitor enable", 1'b1, slowXtalFreqMonitorEn);
		chkBit("source select", 1'b1, mainSourceSelect);
		cpuClockFail <= 1'b0;
		mainClockFail <= 1'b0;
		cyc(3);
		chkBit("nmi follows failure", 1'b0, nmiRequest);
		writeProtectEnable <= 1'b1;
		wr(OFF_MAIN_OSC, 32'h0037_0008);
		wr(OFF_PLL_A, 32'h2001_3F01);
		rd(OFF_MAIN_OSC, rdv);
		chk32("protected osc", 32'h1F00_0008, rdv);
		rd(OFF_PLL_A, rdv);
		chk32("protected pll", 32'h3F00, rdv);
		writeProtectEnable <= 1'b0;
		wr(OFF_MAIN_OSC, 32'h0037_0028);
		cyc(2);
		chk32("rc freq applied", 32'h2, {29'h0, rcFreqSelect});
		chkBit("source rc", 1'b0, mainSourceSelect);
		// frequency change beside an enable change must be dropped
		wr(OFF_MAIN_OSC, 32'h0037_0030);
		rd(OFF_MAIN_OSC, rdv);
		chk32("freq with enable change", 32'h20, rdv);
		poll(OFF_STATUS, 32'h0002_0000, 32'h0, 10);
		wr(OFF_MAIN_OSC, 32'h0037_0028);
		wr(OFF_MAIN_OSC, 32'h0037_0038);
		rd(OFF_MAIN_OSC, rdv);
		chk32("freq while unstable", 32'h28, rdv);
		poll(OFF_STATUS, 32'h0002_0000, 32'h0002_0000, 60);
		poll(OFF_STATUS, 32'h1, 32'h0, 1);
		wr(OFF_MAIN_OSC, 32'h0037_0229);
		cyc(112);
		chkBit("crystal early", 1'b0, extClockStableFlag);
		poll(OFF_STATUS, 32'h1, 32'h1, 40);
		wr(OFF_MAIN_OSC, 32'h0037_0028);
		poll(OFF_STATUS, 32'h1, 32'h0, 5);
		wr(OFF_MAIN_OSC, 32'h0037_002A);
		cyc(2);
		chkBit("bypass stable", 1'b1, extClockStableFlag);
		chkBit("bypass pin", 1'b1, xtalBypass);
		chkBit("crystal pin", 1'b0, xtalOscEnable);
		chkBit("rc enable pin", 1'b1, rcOscEnable);
		chkBit("rc stable pin", 1'b1, rcStableFlag);
		// measurement: rc period 4, ext period 8, window 128 fast cycles
		wr(OFF_FREQ_MEAS, 32'h0010_0000);
		poll(OFF_FREQ_MEAS, 32'h0001_0000, 32'h0, 3);
		poll(OFF_FREQ_MEAS, 32'h0001_0000, 32'h0001_0000, 120);
		rd(OFF_FREQ_MEAS, rdv);
		chk32("rc count", 32'h0001_0020, rdv);
		wr(OFF_FREQ_MEAS, 32'h0110_0000);
		poll(OFF_FREQ_MEAS, 32'h0001_0000, 32'h0, 3);
		poll(OFF_FREQ_MEAS, 32'h0001_0000, 32'h0001_0000, 120);
		rd(OFF_FREQ_MEAS, rdv);
		chk32("ext count", 32'h0101_0010, rdv);
		wr(OFF_FREQ_MEAS, 32'h0100_0000);
		rd(OFF_FREQ_MEAS, rdv);
		chk32("restart zero", 32'h0101_0010, rdv);
		wr(OFF_MAIN_OSC, 32'h0037_0028);
		rd(OFF_FREQ_MEAS, rdv);
		chk32("ready osc off", 32'h0, rdv & 32'h0001_0000);
		for (i = 0; i < 5; i++) begin
			wv = 32'h2000_0300 | (32'(mulT[i]) << 16) | (32'(i % 4) << 14) | 32'(divT[i]);
			wr(OFF_PLL_A, wv);
			cyc(2);
			chkBit("pll a enable", enT[i], pllEnable[0]);
			chk32("pll a factor", enT[i] ? 32'(mulT[i]) + 32'h1 : 32'h0,
				{20'h0, pllFactor[0]});
			chk32("pll a prediv", {24'h0, divT[i]}, {24'h0, pllPrediv[0]});
			chk32("pll a vco", 32'(i % 4), {30'h0, vcoRange[0]});
			rd(OFF_PLL_A, rdv);
			chk32("pll a readback", wv, rdv);
		end
		wr(OFF_PLL_A, 32'h2004_C302);
		cyc(12);
		chkBit("lock early", 1'b0, pllALocked);
		poll(OFF_STATUS, 32'h2, 32'h2, 20);
		// a rewrite of a locked pll must drop the flag at once
		wr(OFF_PLL_A, 32'h2004_C302);
		cyc(2);
		chkBit("lock cleared", 1'b0, pllALocked);
		wr(OFF_PLL_A, 32'h2000_0301);
		cyc(40);
		chkBit("lock disabled", 1'b0, pllALocked);
		for (i = 0; i < 4; i++) begin
			wr(OFF_PLL_B, (32'(i) << 29) | 32'h0001_C101);
			cyc(2);
			chkBit("pll b second rc", i != 0, pllBSecondRc);
		end
		poll(OFF_STATUS, 32'h4, 32'h4, 20);
		chkBit("pll b locked", 1'b1, pllBLocked);
		chkBit("pll b enable", 1'b1, pllEnable[1]);
		chk32("pll b factor", 32'h2, {20'h0, pllFactor[1]});
		chk32("pll b prediv", 32'h1, {24'h0, pllPrediv[1]});
		chk32("pll b vco", 32'h3, {30'h0, vcoRange[1]});
		wr(OFF_MCLK, 32'hFFFF_FFFF);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(OFF_MCLK, rdv);
		chk32("master clock", 32'h173, rdv);
		// read data must fall back to zero one cycle later
		cyc(1);
		chk32("read data one cycle", 32'h0, regRdData);
		chk32("master clock port", 32'h173, masterClockConfig);
		rd(8'h10, rdv);
		chk32("unmapped", 32'h0, rdv);
		stop_test();
	end
endmodule : cgc_top_tb
`default_nettype wire
